// [inc/btc_pkg.sv]
// btc_pkg: constants, types and register map of the bit-test / call executor.
// assumes one 10 MHz clock and a byte-wide memory port on the same clock.
`default_nettype none

package btc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses on the avalon slave
    localparam int BTC_AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_PC = 8'h08;
    localparam logic [7:0] OFF_SP = 8'h0c;
    localparam logic [7:0] OFF_PTR = 8'h10;
    localparam logic [7:0] OFF_IX1 = 8'h14;
    localparam logic [7:0] OFF_IX2 = 8'h18;
    localparam logic [7:0] OFF_AF = 8'h1c;
    localparam logic [7:0] OFF_BCDE = 8'h20;
    localparam logic [7:0] OFF_STKLIM = 8'h24;
    localparam logic [7:0] OFF_IST = 8'h28;
    localparam logic [7:0] OFF_IMASK = 8'h2c;
    localparam logic [7:0] OFF_DSEL = 8'h30;
    localparam logic [7:0] OFF_DRES = 8'h34;

    // values after reset
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic [15:0] RST_SP = 16'h0000;
    localparam logic [15:0] RST_STKLIM = 16'h0000;

    // flag byte layout
    localparam int FL_S = 7;
    localparam int FL_Z = 6;
    localparam int FL_H = 4;
    localparam int FL_PV = 2;
    localparam int FL_N = 1;
    localparam int FL_C = 0;

    // interrupt status / mask bits
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_STKW = 1;
    localparam int IRQ_ILL = 2;

    // opcode bytes
    localparam logic [7:0] OP_BITPFX = 8'hcb;
    localparam logic [7:0] PFX_FIRST = 8'hdd;
    localparam logic [7:0] PFX_SECOND = 8'hfd;
    localparam logic [7:0] OP_CALL = 8'hcd;
    localparam logic [2:0] OP_CALL_CC_LO = 3'b100;
    localparam logic [1:0] OP_TOP = 2'b11;
    localparam logic [1:0] OP_BIT_GRP = 2'b01;
    localparam logic [2:0] R_MEM = 3'b110;

    // condition field codes
    localparam logic [2:0] CC_NONZERO = 3'b000;
    localparam logic [2:0] CC_ZERO = 3'b001;
    localparam logic [2:0] CC_NOCARRY = 3'b010;
    localparam logic [2:0] CC_CARRY = 3'b011;
    localparam logic [2:0] CC_PARITY_ODD = 3'b100;
    localparam logic [2:0] CC_PARITY_EVEN = 3'b101;
    localparam logic [2:0] CC_PLUS = 3'b110;
    localparam logic [2:0] CC_MINUS = 3'b111;

    // operand field codes
    localparam logic [2:0] RX_HIGH = 3'b100;
    localparam logic [2:0] RX_LOW = 3'b101;
    localparam logic [2:0] XX_FIRST = 3'b001;
    localparam logic [2:0] XX_SECOND = 3'b010;
    localparam logic [2:0] XX_PTR = 3'b011;
    localparam logic [2:0] BX_PTR_FIRST = 3'b001;
    localparam logic [2:0] BX_PTR_SECOND = 3'b010;

    // decoder-probe kinds
    localparam logic [1:0] DK_RX = 2'd0;
    localparam logic [1:0] DK_XX = 2'd1;
    localparam logic [1:0] DK_BX = 2'd2;

    // instruction kinds and lengths
    localparam logic [1:0] K_BIT_R = 2'd0;
    localparam logic [1:0] K_BIT_M = 2'd1;
    localparam logic [1:0] K_CALL = 2'd2;
    localparam logic [2:0] LEN_1 = 3'd1;
    localparam logic [2:0] LEN_2 = 3'd2;
    localparam logic [2:0] LEN_3 = 3'd3;
    localparam logic [2:0] LEN_4 = 3'd4;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } btc_mem_req_s;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_FETCH = 6'b000010,
        ST_DECODE = 6'b000100,
        ST_OPRD = 6'b001000,
        ST_PUSH_LO = 6'b010000,
        ST_PUSH_HI = 6'b100000
    } btc_state_e;

endpackage

`default_nettype wire

// [logic/btc_bit_call_exec.sv]
// btc_bit_call_exec: fetches, decodes and runs one bit-test or call per step.
// assumes byte memory on the same clock answering each request with one ack pulse.
`timescale 1ns/1ps
`default_nettype none

module btc_bit_call_exec
    import btc_pkg::*;
(
    input wire logic clk, // 10 MHz core clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic [BTC_AW-1:0] avs_address, // register byte address
    input wire logic avs_read, // avalon read request
    input wire logic avs_write, // avalon write request
    input wire logic [31:0] avs_writedata, // avalon write data
    output logic [31:0] avs_readdata, // avalon read data
    output logic avs_waitrequest, // avalon stall
    output btc_mem_req_s mem_req, // memory request, held until ack
    input wire logic [7:0] mem_rdata, // memory read byte, valid with ack
    input wire logic mem_ack, // memory done, one-cycle pulse
    output logic irq // level interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    btc_state_e st_q, st_d;
    logic [15:0] pc_q, pc_d, sp_q, sp_d, ptr_q, ptr_d, ix1_q, ix1_d, ix2_q, ix2_d;
    logic [15:0] af_q, af_d, stklim_q, stklim_d, dst_q, dst_d;
    logic [31:0] bcde_q, bcde_d, dsel_q, dsel_d;
    logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
    logic [7:0] ib_q [0:3];
    logic [7:0] ib_d [0:3];
    logic [2:0] nb_q, nb_d;
    logic [2:0] bsel_q, bsel_d;
    btc_mem_req_s mem_q, mem_d;
    logic irq_q, irq_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;

    // decode results
    logic [2:0] need_len;
    logic illegal;
    logic [1:0] kind;
    logic [7:0] op_byte;
    logic [15:0] ea;
    logic [15:0] call_dst;
    logic [7:0] reg_opnd;
    logic cond_ok;
    logic [15:0] dres;
    logic wr_en;
    logic busy;

    assign wr_en = avs_write & ~wait_q;
    assign busy = (st_q != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // call opcode: unconditional or 11 cc 100
    function automatic logic is_call(input logic [7:0] b);
        return (b == OP_CALL) || (b[7:6] == OP_TOP && b[2:0] == OP_CALL_CC_LO);
    endfunction

    // condition field against the flag byte
    function automatic logic cond_eval(input logic [2:0] cc, input logic [7:0] f);
        logic r;
        r = 1'b0;
        case (cc)
            CC_NONZERO: r = ~f[FL_Z];
            CC_ZERO: r = f[FL_Z];
            CC_NOCARRY: r = ~f[FL_C];
            CC_CARRY: r = f[FL_C];
            CC_PARITY_ODD: r = ~f[FL_PV];
            CC_PARITY_EVEN: r = f[FL_PV];
            CC_PLUS: r = ~f[FL_S];
            CC_MINUS: r = f[FL_S];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode from the bytes gathered so far
    always_comb begin
        need_len = LEN_1;
        illegal = 1'b0;
        kind = K_BIT_R;
        op_byte = ib_q[1];
        ea = ptr_q;
        call_dst = {ib_q[2], ib_q[1]};
        if (ib_q[0] == OP_BITPFX) begin
            need_len = LEN_2;
            op_byte = ib_q[1];
            kind = (ib_q[1][2:0] == R_MEM) ? K_BIT_M : K_BIT_R;
            ea = ptr_q;
            if (nb_q >= LEN_2 && ib_q[1][7:6] != OP_BIT_GRP) begin
                illegal = 1'b1;
            end
        end else if (is_call(ib_q[0])) begin
            need_len = LEN_3;
            kind = K_CALL;
            op_byte = ib_q[0];
            call_dst = {ib_q[2], ib_q[1]}; // low byte first
        end else if (ib_q[0] == PFX_FIRST || ib_q[0] == PFX_SECOND) begin
            need_len = LEN_2;
            if (nb_q >= LEN_2) begin
                if (ib_q[1] == OP_BITPFX) begin
                    // short indexed: prefix, bit prefix, d, op
                    need_len = LEN_4;
                    kind = K_BIT_M;
                    op_byte = ib_q[3];
                    ea = ((ib_q[0] == PFX_FIRST) ? ix1_q : ix2_q) + {{8{ib_q[2][7]}}, ib_q[2]};
                    if (nb_q >= LEN_4 && (ib_q[3][7:6] != OP_BIT_GRP || ib_q[3][2:0] != R_MEM)) begin
                        illegal = 1'b1;
                    end
                end else if (is_call(ib_q[1])) begin
                    kind = K_CALL;
                    op_byte = ib_q[1];
                    if (ib_q[0] == PFX_FIRST) begin
                        need_len = LEN_2;
                        call_dst = ptr_q;
                    end else begin
                        // relative to the byte after the instruction
                        need_len = LEN_4;
                        call_dst = pc_q + {ib_q[3], ib_q[2]};
                    end
                end else begin
                    illegal = 1'b1;
                end
            end
        end else begin
            illegal = 1'b1;
        end
    end

    // register operand of a bit test, 110 means memory
    always_comb begin
        case (op_byte[2:0])
            3'b000: reg_opnd = bcde_q[31:24];
            3'b001: reg_opnd = bcde_q[23:16];
            3'b010: reg_opnd = bcde_q[15:8];
            3'b011: reg_opnd = bcde_q[7:0];
            3'b100: reg_opnd = ptr_q[15:8];
            3'b101: reg_opnd = ptr_q[7:0];
            3'b111: reg_opnd = af_q[15:8];
            default: reg_opnd = 8'h00;
        endcase
    end

    // unconditional opcode ignores the condition field
    assign cond_ok = (op_byte == OP_CALL) ? 1'b1 : cond_eval(op_byte[5:3], af_q[7:0]);

    ////////////////////////////////////////////////////////////////////////////
    // operand-field probe: software picks a field and reads the resulting value
    always_comb begin
        dres = 16'h0000;
        case (dsel_q[5:4])
            DK_RX: begin
                if (dsel_q[2:0] == RX_HIGH) begin
                    dres = {8'h00, (dsel_q[6] ? ix2_q[15:8] : ix1_q[15:8])};
                end else if (dsel_q[2:0] == RX_LOW) begin
                    dres = {8'h00, (dsel_q[6] ? ix2_q[7:0] : ix1_q[7:0])};
                end
            end
            DK_XX: begin
                case (dsel_q[2:0])
                    XX_FIRST: dres = ix1_q + dsel_q[31:16];
                    XX_SECOND: dres = ix2_q + dsel_q[31:16];
                    XX_PTR: dres = ptr_q + dsel_q[31:16];
                    default: dres = 16'h0000;
                endcase
            end
            DK_BX: begin
                case (dsel_q[2:0])
                    BX_PTR_FIRST: dres = ptr_q + ix1_q;
                    BX_PTR_SECOND: dres = ptr_q + ix2_q;
                    default: dres = 16'h0000;
                endcase
            end
            default: dres = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // core next state: software writes while idle, then the sequencer
    always_comb begin
        st_d = st_q;
        pc_d = pc_q;
        sp_d = sp_q;
        ptr_d = ptr_q;
        ix1_d = ix1_q;
        ix2_d = ix2_q;
        af_d = af_q;
        bcde_d = bcde_q;
        stklim_d = stklim_q;
        dsel_d = dsel_q;
        imask_d = imask_q;
        dst_d = dst_q;
        ib_d = ib_q;
        nb_d = nb_q;
        bsel_d = bsel_q;
        mem_d = mem_q;
        ev = '0;

        // machine state is frozen against software while a step runs
        if (wr_en && !busy) begin
            case (avs_address)
                OFF_PC: pc_d = avs_writedata[15:0];
                OFF_SP: sp_d = avs_writedata[15:0];
                OFF_PTR: ptr_d = avs_writedata[15:0];
                OFF_IX1: ix1_d = avs_writedata[15:0];
                OFF_IX2: ix2_d = avs_writedata[15:0];
                OFF_AF: af_d = avs_writedata[15:0];
                OFF_BCDE: bcde_d = avs_writedata;
                OFF_STKLIM: stklim_d = avs_writedata[15:0];
                OFF_DSEL: dsel_d = avs_writedata;
                default: ;
            endcase
        end
        if (wr_en && avs_address == OFF_IMASK) begin
            imask_d = avs_writedata[IRQ_W-1:0];
        end

        case (st_q)
            ST_IDLE: begin
                if (wr_en && avs_address == OFF_CTRL && avs_writedata[0]) begin
                    nb_d = 3'd0;
                    mem_d.rd = 1'b1;
                    mem_d.addr = pc_q;
                    st_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (mem_ack) begin
                    ib_d[nb_q[1:0]] = mem_rdata;
                    nb_d = nb_q + 3'd1;
                    pc_d = pc_q + 16'h0001; // pc ends past the whole instruction
                    mem_d.rd = 1'b0;
                    st_d = ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (illegal) begin
                    ev[IRQ_ILL] = 1'b1;
                    st_d = ST_IDLE;
                end else if (nb_q < need_len) begin
                    mem_d.rd = 1'b1;
                    mem_d.addr = pc_q;
                    st_d = ST_FETCH;
                end else if (kind == K_BIT_R) begin
                    // only z, h, n move; s, p/v, c kept
                    af_d[FL_Z] = ~reg_opnd[op_byte[5:3]];
                    af_d[FL_H] = 1'b1;
                    af_d[FL_N] = 1'b0;
                    ev[IRQ_DONE] = 1'b1;
                    st_d = ST_IDLE;
                end else if (kind == K_BIT_M) begin
                    bsel_d = op_byte[5:3];
                    mem_d.rd = 1'b1;
                    mem_d.addr = ea;
                    st_d = ST_OPRD;
                end else if (cond_ok) begin
                    // taken: flags never touched on this path
                    dst_d = call_dst;
                    sp_d = sp_q - 16'h0002;
                    mem_d.wr = 1'b1;
                    mem_d.addr = sp_q - 16'h0002;
                    mem_d.wdata = pc_q[7:0]; // return address, low byte
                    st_d = ST_PUSH_LO;
                end else begin
                    // not taken: pc already sequential, stack untouched
                    ev[IRQ_DONE] = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            ST_OPRD: begin
                if (mem_ack) begin
                    // memory operand only read, never written back
                    af_d[FL_Z] = ~mem_rdata[bsel_q];
                    af_d[FL_H] = 1'b1;
                    af_d[FL_N] = 1'b0;
                    mem_d.rd = 1'b0;
                    ev[IRQ_DONE] = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            ST_PUSH_LO: begin
                if (mem_ack) begin
                    mem_d.addr = sp_q + 16'h0001;
                    mem_d.wdata = pc_q[15:8];
                    st_d = ST_PUSH_HI;
                end
            end
            ST_PUSH_HI: begin
                if (mem_ack) begin
                    mem_d.wr = 1'b0;
                    pc_d = dst_q;
                    // checked only once both bytes are in memory
                    ev[IRQ_STKW] = (sp_q < stklim_q);
                    ev[IRQ_DONE] = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase

        // sticky status: a new event beats a write-one clear
        ist_d = ist_q;
        if (wr_en && avs_address == OFF_IST) begin
            ist_d = ist_q & ~avs_writedata[IRQ_W-1:0];
        end
        ist_d = ist_d | ev;
        irq_d = |(ist_d & imask_d);
    end

    // core registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
            pc_q <= RST_PC;
            sp_q <= RST_SP;
            ptr_q <= 16'h0000;
            ix1_q <= 16'h0000;
            ix2_q <= 16'h0000;
            af_q <= 16'h0000;
            bcde_q <= 32'h0000_0000;
            stklim_q <= RST_STKLIM;
            dsel_q <= 32'h0000_0000;
            imask_q <= '0;
            ist_q <= '0;
            dst_q <= 16'h0000;
            for (int i = 0; i < 4; i++) begin
                ib_q[i] <= 8'h00;
            end
            nb_q <= 3'd0;
            bsel_q <= 3'd0;
            mem_q <= '0;
            irq_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            ptr_q <= ptr_d;
            ix1_q <= ix1_d;
            ix2_q <= ix2_d;
            af_q <= af_d;
            bcde_q <= bcde_d;
            stklim_q <= stklim_d;
            dsel_q <= dsel_d;
            imask_q <= imask_d;
            ist_q <= ist_d;
            dst_q <= dst_d;
            ib_q <= ib_d;
            nb_q <= nb_d;
            bsel_q <= bsel_d;
            mem_q <= mem_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then waitrequest low for exactly one cycle
    always_comb begin
        wait_d = ~((avs_read | avs_write) & wait_q);
        rdata_d = rdata_q;
        if ((avs_read | avs_write) && wait_q) begin
            case (avs_address)
                OFF_STAT: rdata_d = {28'h000_0000, nb_q, busy}; // busy in bit 0, count above
                OFF_PC: rdata_d = {16'h0000, pc_q};
                OFF_SP: rdata_d = {16'h0000, sp_q};
                OFF_PTR: rdata_d = {16'h0000, ptr_q};
                OFF_IX1: rdata_d = {16'h0000, ix1_q};
                OFF_IX2: rdata_d = {16'h0000, ix2_q};
                OFF_AF: rdata_d = {16'h0000, af_q};
                OFF_BCDE: rdata_d = bcde_q;
                OFF_STKLIM: rdata_d = {16'h0000, stklim_q};
                OFF_IST: rdata_d = {29'h0, ist_q};
                OFF_IMASK: rdata_d = {29'h0, imask_q};
                OFF_DSEL: rdata_d = dsel_q;
                OFF_DRES: rdata_d = {16'h0000, dres};
                default: rdata_d = 32'h0000_0000; // ctrl and holes read zero
            endcase
        end
    end

    // waitrequest rests high so a new request always waits one cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    assign mem_req = mem_q;
    assign irq = irq_q;

endmodule // btc_bit_call_exec

`default_nettype wire

// [tb/btc_bit_call_exec_chk.sv]
// btc_chk: bus and push checks on the executor's ports.
// assumes one clock and nrst synchronous, active low.
`timescale 1ns/1ps
`default_nettype none
module btc_chk
    import btc_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic nrst, // sync reset
    input wire logic [BTC_AW-1:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [31:0] avs_writedata, // wdata
    input wire logic [31:0] avs_readdata, // rdata
    input wire logic avs_waitrequest, // stall
    input wire btc_mem_req_s mem_req, // memory request
    input wire logic [7:0] mem_rdata, // memory byte
    input wire logic mem_ack, // memory done
    input wire logic irq // interrupt
);
    logic [15:0] lra_q; // last read address
    logic hi_q; // second push half due
    ////////////////////////////////////////
    // return value must follow the last fetched byte
    always_ff @(posedge clk) begin
        if (!nrst) begin
            lra_q <= 16'h0000;
            hi_q <= 1'b0;
        end else begin
            if (mem_req.rd && mem_ack) lra_q <= mem_req.addr;
            if (mem_req.wr && mem_ack) hi_q <= !hi_q;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low twice");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("no bus answer");
    a_req_hold: assert property ((mem_req.rd || mem_req.wr) && !mem_ack |=>
        $stable(mem_req)) else $error("memory request moved");
    a_rd_wr_excl: assert property (!(mem_req.rd && mem_req.wr))
        else $error("read and write together");
    a_push_pair: assert property (mem_req.wr && mem_ack && !hi_q |=> mem_req.wr &&
        mem_req.addr == $past(mem_req.addr) + 16'h1) else $error("push halves wrong");
    a_ret_addr: assert property (mem_req.wr && mem_ack && !hi_q |=>
        {mem_req.wdata, $past(mem_req.wdata)} == lra_q + 16'h1) else $error("bad return");
    a_read_drop: assert property (mem_req.rd && mem_ack |=> !mem_req.rd)
        else $error("read held after ack");
    a_rst_quiet: assert property (disable iff (1'b0) !nrst |=> avs_waitrequest &&
        !irq && !mem_req.rd && !mem_req.wr) else $error("outputs not reset");
    c_push: cover property (mem_req.wr && mem_ack && hi_q);
    c_irq: cover property ($rose(irq));
    c_bus: cover property (avs_read && !avs_waitrequest);
endmodule // btc_chk
bind btc_bit_call_exec btc_chk u_chk (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_req, .mem_rdata, .mem_ack, .irq);
`default_nettype wire

// [tb/btc_mem_model.sv]
// btc_mem_model: byte memory for program, data and stack.
// assumes the executor's request/ack port on the same clock.
`timescale 1ns/1ps
`default_nettype none
module btc_mem_model
    import btc_pkg::*;
(
    input wire logic clk, // core clock
    input wire btc_mem_req_s req, // request, held until ack
    output logic [7:0] rdata, // read byte, valid with ack
    output logic ack // one-cycle done pulse
);
    logic [7:0] mem [0:65535];
    logic slow_q;
    logic wait_q;
    ////////////////////////////////////////
    // alternate prompt and one-wait answers; data churns outside ack
    initial begin
        ack = 1'b0;
        rdata = 8'h00;
        slow_q = 1'b0;
        wait_q = 1'b0;
    end
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if ((req.rd || req.wr) && !ack) begin
            if (slow_q && !wait_q) wait_q <= 1'b1;
            else begin
                ack <= 1'b1;
                wait_q <= 1'b0;
                slow_q <= !slow_q;
                if (req.wr) mem[req.addr] <= req.wdata;
                else rdata <= mem[req.addr];
            end
        end
    end
endmodule // btc_mem_model
`default_nettype wire

// [tb/tb_bit_test_and_call_exec.sv]
// tb_bit_test_and_call_exec: self-checking bench for the executor.
// assumes package, executor, memory model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_bit_test_and_call_exec;
    import btc_pkg::*;
    typedef struct packed {
        logic [15:0] af;
        logic [31:0] code;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] afx;
        logic [15:0] rt;
    } btc_row_s;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [BTC_AW-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    btc_mem_req_s mem_req;
    logic [7:0] mem_rdata;
    logic mem_ack;
    logic irq;
    logic [31:0] rq;
    int err_count = 0;
    int check_count = 0;
    // flags, code bytes, then pc, sp, flags and pushed value expected
    btc_row_s rows [8] = '{
        '{16'h0000, 32'h002520cd, 16'h2520, 16'hff24, 16'h0000, 16'h1633},
        '{16'h1643, 32'h00004fcb, 16'h1632, 16'hff26, 16'h1611, 16'h0000},
        '{16'h1686, 32'h000047cb, 16'h1632, 16'hff26, 16'h16d4, 16'h0000},
        '{16'h0040, 32'h00007ecb, 16'h1632, 16'hff26, 16'h0010, 16'h0000},
        '{16'h00ff, 32'h0010cdfd, 16'h1644, 16'hff24, 16'h00ff, 16'h1634},
        '{16'h0000, 32'h0000cddd, 16'h4000, 16'hff24, 16'h0000, 16'h1632},
        '{16'h0000, 32'h46f0cbdd, 16'h1634, 16'hff26, 16'h0050, 16'h0000},
        '{16'h00ff, 32'h00000000, 16'h1631, 16'hff26, 16'h00ff, 16'h0000}};
    btc_bit_call_exec uut (.clk, .nrst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_req, .mem_rdata, .mem_ack, .irq);
    btc_mem_model u_mem (.clk, .req(mem_req), .rdata(mem_rdata), .ack(mem_ack));
    always #50 clk = ~clk;
    ////////////////////////////////////////
    task automatic finish_test;
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (avs_waitrequest !== 1'b0) err_count++;
        rq = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    // pick an operand field through the probe and compare its value
    task automatic probe(input logic [31:0] sel, input logic [31:0] exp);
        bus(1'b1, OFF_DSEL, sel);
        bus(1'b0, OFF_DRES, '0);
        cmp(rq, exp);
    endtask
    // load one instruction at 1630, step it, compare the outcome
    task automatic run(input btc_row_s r);
        int n;
        n = 0;
        for (int i = 0; i < 4; i++) u_mem.mem[16'h1630 + i] = r.code[8*i +: 8];
        u_mem.mem[16'hff24] = 8'h00;
        u_mem.mem[16'hff25] = 8'h00;
        bus(1'b1, OFF_PC, 32'h1630);
        bus(1'b1, OFF_SP, 32'hff26);
        bus(1'b1, OFF_AF, {16'h0, r.af});
        bus(1'b1, OFF_PTR, 32'h4000);
        bus(1'b1, OFF_CTRL, 32'h1);
        do begin
            bus(1'b0, OFF_STAT, '0);
            n++;
        end while (rq[0] !== 1'b0 && n < 50);
        if (rq[0] !== 1'b0) err_count++;
        bus(1'b0, OFF_PC, '0);
        cmp(rq, {16'h0, r.pc});
        bus(1'b0, OFF_SP, '0);
        cmp(rq, {16'h0, r.sp});
        bus(1'b0, OFF_AF, '0);
        cmp(rq, {16'h0, r.afx});
        cmp({16'h0, u_mem.mem[16'hff25], u_mem.mem[16'hff24]}, {16'h0, r.rt});
    endtask
    initial begin
        btc_row_s r;
        u_mem.mem[16'h4000] = 8'h80;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        bus(1'b0, OFF_SP, '0);
        cmp(rq, {16'h0, RST_SP});
        bus(1'b1, 8'h40, 32'h5);
        bus(1'b0, 8'h40, '0);
        cmp(rq, '0);
        // first index sits above the operand so a negative displacement reaches it
        bus(1'b1, OFF_IX1, 32'h4010);
        foreach (rows[k]) run(rows[k]);
        cmp({24'h0, u_mem.mem[16'h4000]}, 32'h80);
        // done and illegal-opcode events, no stack warning from any row
        bus(1'b0, OFF_IST, '0);
        cmp(rq, 32'h5);
        // operand-field encodings through the probe
        bus(1'b1, OFF_IX2, 32'h1234);
        probe(32'h0000_0004, 32'h40);
        probe(32'h0000_0045, 32'h34);
        probe(32'h0100_0011, 32'h4110);
        probe(32'h0100_0012, 32'h1334);
        probe(32'h0100_0013, 32'h4100);
        probe(32'h0000_0021, 32'h8010);
        // every condition code, once true and once false
        for (int i = 0; i < 16; i++) begin
            r = rows[0];
            r.af = i[3] ? 16'h00c5 : 16'h0000;
            r.afx = r.af;
            r.code[7:0] = 8'hc4 | {2'b00, i[2:0], 3'b000};
            if (i[0] != i[3]) begin
                r.pc = 16'h1633;
                r.sp = 16'hff26;
                r.rt = 16'h0000;
            end
            run(r);
        end
        // stack warning raises irq, masked and cleared
        bus(1'b1, OFF_STKLIM, 32'hff25);
        bus(1'b1, OFF_IMASK, 32'h2);
        bus(1'b1, OFF_IST, 32'h7);
        run(rows[0]);
        repeat (2) @(posedge clk);
        cmp({31'h0, irq}, 32'h1);
        bus(1'b1, OFF_IST, 32'h2);
        // limit above the stack so a wrongly raised warning would show
        bus(1'b1, OFF_STKLIM, 32'hffff);
        run(rows[1]);
        repeat (2) @(posedge clk);
        cmp({31'h0, irq}, 32'h0);
        bus(1'b0, OFF_IST, '0);
        cmp(rq, 32'h1);
        finish_test();
    end
    // cut a hang short
    initial begin
        #(100 * 80000);
        err_count++;
        finish_test();
    end
endmodule // tb_bit_test_and_call_exec
`default_nettype wire
